// ---- inc/limit_switch_defines.svh ----
// constants for the switch-output block
`ifndef LIMIT_SWITCH_DEFINES_SVH
`define LIMIT_SWITCH_DEFINES_SVH

// register offsets (word index times four)
`define REG_ROLE        8'h00
`define REG_CLASS       8'h04
`define REG_ON_VALUE    8'h08
`define REG_OFF_VALUE   8'h0C
`define REG_ON_DELAY    8'h10
`define REG_OFF_DELAY   8'h14
`define REG_ERR_MODE    8'h18
`define REG_INVERT      8'h1C
`define REG_DIG_SRC     8'h20
`define REG_LIMIT_SRC   8'h24
`define REG_STATUS      8'h28

// delay settings in tenths of a second
`define DELAY_MAX       11'h03E8
`define TENTH_NS        100_000_000
`define CLOCK_NS        20
`define TENTH_CYCLES    (`TENTH_NS / `CLOCK_NS)

// reset values
`define THRESH_RESET    32'h0000_0000
`define DELAY_RESET     11'h000

`endif

// ---- inc/limit_switch_pkg.sv ----
// types shared by the switch-output block
package limit_switch_pkg;
    typedef enum logic [1:0] {
        ROLE_OFF   = 2'h0,
        ROLE_DIAG  = 2'h1,
        ROLE_LIMIT = 2'h2,
        ROLE_DIG   = 2'h3
    } role_t;

    typedef enum logic [1:0] {
        CLASS_ALARM    = 2'h0,
        CLASS_ALARM_OR = 2'h1,
        CLASS_WARNING  = 2'h2
    } event_class_t;

    typedef enum logic [1:0] {
        ERR_KEEP   = 2'h0,
        ERR_OPEN   = 2'h1,
        ERR_CLOSED = 2'h2
    } err_mode_t;

    typedef enum logic [1:0] {
        DIG_OFF = 2'h0,
        DIG_ONE = 2'h1,
        DIG_TWO = 2'h2
    } dig_src_t;
endpackage

// ---- design/float_less.sv ----
// signed ieee-754 single compare: a strictly below b
`timescale 1ns/1ns
module float_less (
    input  wire logic [31:0] a,    // first operand
    input  wire logic [31:0] b,    // second operand
    output logic             less  // a < b
);
    logic a_zero;
    logic b_zero;

    always_comb begin
        // +0 and -0 compare equal
        a_zero = (a[30:0] == 31'h0000_0000);
        b_zero = (b[30:0] == 31'h0000_0000);
        if (a_zero && b_zero) begin
            less = 1'b0;
        end else if (a[31] != b[31]) begin
            less = a[31];
        end else if (a[31]) begin
            less = (a[30:0] > b[30:0]);
        end else begin
            less = (a[30:0] < b[30:0]);
        end
    end
endmodule

// ---- design/limit_switch_output.sv ----
// switch-output logic: diagnostic, limit with hysteresis or digital source
// What this block does
// - in diagnostic role the output follows alarm, alarm-or-warning or warning, alarm after reset.
// - in limit role the output closes when the value rises above the on-threshold, reset zero.
// - in limit role the output opens when the value falls below the off-threshold, reset zero.
// - both thresholds are signed floating-point numbers compared with sign.
// - with on above off, close above on and open below off.
// - with on below off, close below on and open above off.
// - with a limit source selected a close waits a 0.0 to 100.0 s delay, zero after reset.
// - with a limit source selected an open waits its own 0.0 to 100.0 s delay, zero after reset.
// - on device error the output keeps its state, opens or closes as selected, open after reset.
// - the error selection acts only in limit or digital role, not in diagnostic role.
// - the present open or closed state can be read back.
// - inversion swaps open and closed, off after reset.
// - in digital role one of two switch signals or none drives the output, none after reset.
`timescale 1ns/1ns
`include "limit_switch_defines.svh"
module limit_switch_output
    import limit_switch_pkg::*;
#(
    parameter int TENTH_CYCLES = `TENTH_CYCLES
) (
    input  wire logic        clock,        // 50 MHz clock
    input  wire logic        reset,        // synchronous, active high
    input  wire logic [7:0]  address,      // register byte address
    input  wire logic [31:0] write_data,   // register write data
    input  wire logic        write_strobe, // one-cycle write
    input  wire logic        read_strobe,  // one-cycle read
    output logic      [31:0] read_data,    // read data, cycle after strobe
    input  wire logic [31:0] process_value,// monitored variable, ieee single
    input  wire logic        diag_alarm,   // alarm event active
    input  wire logic        diag_warning, // warning event active
    input  wire logic        device_error, // device error present
    input  wire logic        dig_one,      // diagnostic-block switch signal 1
    input  wire logic        dig_two,      // diagnostic-block switch signal 2
    output logic             switch_closed // output pin, high = closed
);
    logic [1:0]  role;
    logic [1:0]  event_class;
    logic [31:0] on_value;
    logic [31:0] off_value;
    logic [10:0] on_delay;
    logic [10:0] off_delay;
    logic [1:0]  err_mode;
    logic        invert;
    logic [1:0]  dig_src;
    logic        limit_src;
    logic [1:0]  next_role;
    logic [1:0]  next_event_class;
    logic [31:0] next_on_value;
    logic [31:0] next_off_value;
    logic [10:0] next_on_delay;
    logic [10:0] next_off_delay;
    logic [1:0]  next_err_mode;
    logic        next_invert;
    logic [1:0]  next_dig_src;
    logic        next_limit_src;
    logic [31:0] next_read_data;

    // inputs from outside the clock domain pass two flip-flops
    logic [4:0]  sync_a;
    logic [4:0]  sync_b;
    // the value word is synchronised bit by bit: it must stay steady for a few cycles
    logic [31:0] pv_a;
    logic [31:0] pv_b;
    always_ff @(posedge clock) begin
        sync_a <= {diag_alarm, diag_warning, device_error, dig_one, dig_two};
        sync_b <= sync_a;
        pv_a   <= process_value;
        pv_b   <= pv_a;
    end
    logic alarm_s;
    logic warn_s;
    logic err_s;
    logic one_s;
    logic two_s;
    assign {alarm_s, warn_s, err_s, one_s, two_s} = sync_b;

    function automatic logic [10:0] clamp_delay(input logic [31:0] v);
        if (v > 32'(`DELAY_MAX)) begin
            return `DELAY_MAX;
        end
        return v[10:0];
    endfunction

    always_comb begin
        next_role        = role;
        next_event_class = event_class;
        next_on_value    = on_value;
        next_off_value   = off_value;
        next_on_delay    = on_delay;
        next_off_delay   = off_delay;
        next_err_mode    = err_mode;
        next_invert      = invert;
        next_dig_src     = dig_src;
        next_limit_src   = limit_src;
        if (write_strobe) begin
            case (address)
                `REG_ROLE:      next_role = write_data[1:0];
                `REG_CLASS: begin
                    if (write_data[1:0] != 2'h3) begin
                        next_event_class = write_data[1:0];
                    end
                end
                `REG_ON_VALUE:  next_on_value = write_data;
                `REG_OFF_VALUE: next_off_value = write_data;
                `REG_ON_DELAY:  next_on_delay = clamp_delay(write_data);
                `REG_OFF_DELAY: next_off_delay = clamp_delay(write_data);
                `REG_ERR_MODE: begin
                    if (write_data[1:0] != 2'h3) begin
                        next_err_mode = write_data[1:0];
                    end
                end
                `REG_INVERT:    next_invert = write_data[0];
                `REG_DIG_SRC: begin
                    if (write_data[1:0] != 2'h3) begin
                        next_dig_src = write_data[1:0];
                    end
                end
                `REG_LIMIT_SRC: next_limit_src = write_data[0];
                default: ;
            endcase
        end
    end

    always_comb begin
        next_read_data = 32'h0000_0000;
        if (read_strobe) begin
            case (address)
                `REG_ROLE:      next_read_data = {30'h0000_0000, role};
                `REG_CLASS:     next_read_data = {30'h0000_0000, event_class};
                `REG_ON_VALUE:  next_read_data = on_value;
                `REG_OFF_VALUE: next_read_data = off_value;
                `REG_ON_DELAY:  next_read_data = {21'h00_0000, on_delay};
                `REG_OFF_DELAY: next_read_data = {21'h00_0000, off_delay};
                `REG_ERR_MODE:  next_read_data = {30'h0000_0000, err_mode};
                `REG_INVERT:    next_read_data = {31'h0000_0000, invert};
                `REG_DIG_SRC:   next_read_data = {30'h0000_0000, dig_src};
                `REG_LIMIT_SRC: next_read_data = {31'h0000_0000, limit_src};
                `REG_STATUS:    next_read_data = {31'h0000_0000, switch_closed};
                default:        next_read_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            role        <= ROLE_OFF;
            event_class <= CLASS_ALARM;
            on_value    <= `THRESH_RESET;
            off_value   <= `THRESH_RESET;
            on_delay    <= `DELAY_RESET;
            off_delay   <= `DELAY_RESET;
            err_mode    <= ERR_OPEN;
            invert      <= 1'b0;
            dig_src     <= DIG_OFF;
            limit_src   <= 1'b0;
            read_data   <= 32'h0000_0000;
        end else begin
            role        <= next_role;
            event_class <= next_event_class;
            on_value    <= next_on_value;
            off_value   <= next_off_value;
            on_delay    <= next_on_delay;
            off_delay   <= next_off_delay;
            err_mode    <= next_err_mode;
            invert      <= next_invert;
            dig_src     <= next_dig_src;
            limit_src   <= next_limit_src;
            read_data   <= next_read_data;
        end
    end

    logic pv_below_on;
    logic pv_below_off;
    logic on_below_off;
    logic on_below_pv;
    logic off_below_pv;
    float_less cmp_pv_on   (.a(pv_b),      .b(on_value),  .less(pv_below_on));
    float_less cmp_pv_off  (.a(pv_b),      .b(off_value), .less(pv_below_off));
    float_less cmp_on_pv   (.a(on_value),  .b(pv_b),      .less(on_below_pv));
    float_less cmp_off_pv  (.a(off_value), .b(pv_b),      .less(off_below_pv));
    float_less cmp_on_off  (.a(on_value),  .b(off_value), .less(on_below_off));

    logic want_close;
    logic want_open;
    always_comb begin
        want_close = 1'b0;
        want_open  = 1'b0;
        if (on_below_off) begin
            want_close = pv_below_on;
            want_open  = off_below_pv;
        end else begin
            // normal window; equal thresholds fall here
            want_close = on_below_pv;
            want_open  = pv_below_off;
        end
    end

    // limit state with delays; a tenth-second prescaler feeds the delay count
    logic        limit_state;
    logic [10:0] delay_count;
    logic [31:0] tick_count;
    logic        next_limit_state;
    logic [10:0] next_delay_count;
    logic [31:0] next_tick_count;
    logic        pending;
    logic [10:0] target;

    always_comb begin
        next_limit_state = limit_state;
        next_delay_count = `DELAY_RESET;
        next_tick_count  = 32'h0000_0000;
        pending = limit_state ? (want_open && !want_close) : (want_close && !want_open);
        target  = limit_state ? off_delay : on_delay;
        if (!limit_src) begin
            // no source: limit state stays open
            next_limit_state = 1'b0;
        end else if (pending) begin
            if (delay_count >= target) begin
                next_limit_state = !limit_state;
            end else if (tick_count == 32'(TENTH_CYCLES - 1)) begin
                next_delay_count = delay_count + 11'h001;
            end else begin
                next_delay_count = delay_count;
                next_tick_count  = tick_count + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            limit_state <= 1'b0;
            delay_count <= `DELAY_RESET;
            tick_count  <= 32'h0000_0000;
        end else begin
            limit_state <= next_limit_state;
            delay_count <= next_delay_count;
            tick_count  <= next_tick_count;
        end
    end

    // output select
    logic raw_state;
    logic next_switch;
    always_comb begin
        raw_state = 1'b0;
        case (role)
            ROLE_DIAG: begin
                case (event_class)
                    CLASS_ALARM:    raw_state = alarm_s;
                    CLASS_ALARM_OR: raw_state = alarm_s || warn_s;
                    CLASS_WARNING:  raw_state = warn_s;
                    default:        raw_state = alarm_s;
                endcase
            end
            ROLE_LIMIT: raw_state = limit_state;
            ROLE_DIG: begin
                case (dig_src)
                    DIG_ONE: raw_state = one_s;
                    DIG_TWO: raw_state = two_s;
                    default: raw_state = 1'b0;
                endcase
            end
            default: raw_state = 1'b0;
        endcase
        next_switch = raw_state ^ invert;
        if (err_s && (role == ROLE_LIMIT || role == ROLE_DIG)) begin
            case (err_mode)
                ERR_OPEN:   next_switch = 1'b0 ^ invert;
                ERR_CLOSED: next_switch = 1'b1 ^ invert;
                default:    next_switch = switch_closed;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            switch_closed <= 1'b0;
        end else begin
            switch_closed <= next_switch;
        end
    end

    early_switch_a: assert property (@(posedge clock) disable iff (reset)
        (role == ROLE_LIMIT && $changed(limit_state) && $past(limit_src))
        |-> $past(delay_count) >= $past(target))
        else $error("limit state changed before delay elapsed");

    band_hold_a: assert property (@(posedge clock) disable iff (reset)
        (!want_close && !want_open && limit_src) |=> $stable(limit_state))
        else $error("limit state moved inside hysteresis band");

    close_fast_a: assert property (@(posedge clock) disable iff (reset)
        (limit_src && on_delay == 11'h000 && !limit_state && want_close && !want_open
         && $stable(on_delay))
        |=> limit_state)
        else $error("close with zero delay did not happen");

    open_fast_a: assert property (@(posedge clock) disable iff (reset)
        (limit_src && off_delay == 11'h000 && limit_state && want_open && !want_close
         && $stable(off_delay))
        |=> !limit_state)
        else $error("open with zero delay did not happen");

    error_open_a: assert property (@(posedge clock) disable iff (reset)
        (err_s && role == ROLE_LIMIT && err_mode == ERR_OPEN)
        |=> switch_closed == $past(invert))
        else $error("error did not force open");

    diag_error_a: assert property (@(posedge clock) disable iff (reset)
        (role == ROLE_DIAG && event_class == CLASS_ALARM)
        |=> switch_closed == ($past(alarm_s) ^ $past(invert)))
        else $error("diagnostic output not following alarm");

    digital_follow_a: assert property (@(posedge clock) disable iff (reset)
        (role == ROLE_DIG && !err_s && dig_src == DIG_TWO)
        |=> switch_closed == ($past(two_s) ^ $past(invert)))
        else $error("digital output not following source two");

    status_read_a: assert property (@(posedge clock) disable iff (reset)
        (read_strobe && address == `REG_STATUS) |=> read_data[0] == $past(switch_closed))
        else $error("status read does not match output");

    invert_apply_a: assert property (@(posedge clock) disable iff (reset)
        (role == ROLE_LIMIT && !err_s) |=> switch_closed == ($past(limit_state) ^ $past(invert)))
        else $error("inversion not applied to limit state");
endmodule

// ---- bench/limit_switch_output_tb_top.sv ----
// self-checking bench for the switch-output block, register reads scored from a queue
`timescale 1ns/1ns
`include "limit_switch_defines.svh"
module limit_switch_output_tb_top
    import limit_switch_pkg::*;
;
    typedef struct {
        string       name;
        logic [31:0] value;
    } note_t;

    localparam logic [31:0] P3  = 32'h4040_0000;
    localparam logic [31:0] P2  = 32'h4000_0000;
    localparam logic [31:0] P15 = 32'h3FC0_0000;
    localparam logic [31:0] P1  = 32'h3F80_0000;
    localparam logic [31:0] P05 = 32'h3F00_0000;
    localparam logic [31:0] M05 = 32'hBF00_0000;
    localparam logic [31:0] M1  = 32'hBF80_0000;
    localparam logic [31:0] M15 = 32'hBFC0_0000;
    localparam logic [31:0] M2  = 32'hC000_0000;
    localparam logic [31:0] M3  = 32'hC040_0000;

    logic        clock;
    logic        reset;
    logic [7:0]  address;
    logic [31:0] write_data;
    logic        write_strobe;
    logic        read_strobe;
    logic [31:0] read_data;
    logic [31:0] process_value;
    logic        diag_alarm;
    logic        diag_warning;
    logic        device_error;
    logic        dig_one;
    logic        dig_two;
    logic        switch_closed;
    note_t       notes[$];
    note_t       note;
    logic        pending = 1'b0;
    logic [31:0] r;
    logic [7:0]  reg_list [12];
    int          bad_count;
    int          check_count;

    // short tenth-second count keeps the delay scenarios to a few dozen cycles
    limit_switch_output #(.TENTH_CYCLES(4)) DUT (
        .clock         (clock),
        .reset         (reset),
        .address       (address),
        .write_data    (write_data),
        .write_strobe  (write_strobe),
        .read_strobe   (read_strobe),
        .read_data     (read_data),
        .process_value (process_value),
        .diag_alarm    (diag_alarm),
        .diag_warning  (diag_warning),
        .device_error  (device_error),
        .dig_one       (dig_one),
        .dig_two       (dig_two),
        .switch_closed (switch_closed)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // read data stands only in the cycle after the strobe, so score it there
    always @(posedge clock) begin
        if (pending) begin
            check_count++;
            if (notes.size() == 0) begin
                bad_count++;
                $display("wrong value read_data expected none seen %h", read_data);
            end else begin
                note = notes.pop_front();
                if (read_data !== note.value) begin
                    bad_count++;
                    $display("wrong value %s expected %h seen %h", note.name, note.value,
                             read_data);
                end
                // the pin itself must agree with the state read back
                if (note.name == "switch state" && switch_closed !== note.value[0]) begin
                    bad_count++;
                    $display("wrong value switch_closed expected %b seen %b", note.value[0],
                             switch_closed);
                end
            end
        end
        pending <= read_strobe;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one idle edge after each strobe avoids lowering and raising it in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        notes.push_back('{n, e});
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        @(posedge clock);
    endtask

    // eight cycles cover the two sync stages plus the output register
    task automatic st(input logic e);
        tick(8);
        rd(`REG_STATUS, {31'h0, e}, "switch state");
    endtask

    task automatic pv(input logic [31:0] v, input logic e);
        process_value <= v;
        st(e);
    endtask

    task automatic conclude();
        if (notes.size() != 0) bad_count++;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        tick(20000);
        bad_count++;
        $display("wrong value watchdog expected finish seen timeout");
        conclude();
    end

    initial begin
        reset = 1'b1;
        address = 8'h00;
        write_data = 32'h0000_0000;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        process_value = 32'h0000_0000;
        {diag_alarm, diag_warning, device_error, dig_one, dig_two} = 5'h00;
        bad_count = 0;
        check_count = 0;
        reg_list = '{`REG_ROLE, `REG_CLASS, `REG_ON_VALUE, `REG_OFF_VALUE, `REG_ON_DELAY,
                     `REG_OFF_DELAY, `REG_ERR_MODE, `REG_INVERT, `REG_DIG_SRC,
                     `REG_LIMIT_SRC, `REG_STATUS, 8'h2C};
        void'($urandom(86));
        tick(20);
        reset <= 1'b0;
        tick(1);
        foreach (reg_list[i]) begin
            rd(reg_list[i], (reg_list[i] == `REG_ERR_MODE) ? 32'h0000_0001 : 32'h0000_0000,
               "reset value");
        end
        wr(`REG_CLASS, 32'h0000_0003);
        rd(`REG_CLASS, 32'h0000_0000, "class after bad write");
        wr(`REG_ON_DELAY, 32'h0000_07D0);
        rd(`REG_ON_DELAY, 32'h0000_03E8, "clamped delay");
        wr(`REG_ON_DELAY, 32'h0000_0000);
        wr(`REG_STATUS, 32'h0000_0001);
        rd(`REG_STATUS, 32'h0000_0000, "read-only status");
        wr(8'h2C, 32'hFFFF_FFFF);
        rd(8'h2C, 32'h0000_0000, "unmapped");
        wr(`REG_ON_VALUE, M1);
        rd(`REG_ON_VALUE, M1, "negative threshold");
        // diagnostic role ignores the error selection
        wr(`REG_ROLE, 32'h0000_0001);
        wr(`REG_ERR_MODE, 32'h0000_0002);
        for (int c = 0; c < 3; c++) begin
            wr(`REG_CLASS, 32'(c));
            for (int k = 0; k < 6; k++) begin
                r = $urandom();
                diag_alarm <= r[0];
                diag_warning <= r[1];
                device_error <= r[2];
                st(c == 0 ? r[0] : (c == 1 ? (r[0] | r[1]) : r[1]));
            end
        end
        {diag_alarm, diag_warning, device_error} <= 3'h0;
        wr(`REG_ROLE, 32'h0000_0003);
        for (int c = 0; c < 3; c++) begin
            wr(`REG_DIG_SRC, 32'(c));
            for (int k = 0; k < 4; k++) begin
                r = $urandom();
                dig_one <= r[0];
                dig_two <= r[1];
                st(c == 0 ? 1'b0 : (c == 1 ? r[0] : r[1]));
            end
        end
        wr(`REG_DIG_SRC, 32'h0000_0001);
        dig_one <= 1'b0;
        device_error <= 1'b1;
        st(1'b1);
        device_error <= 1'b0;
        // limit role with hysteresis
        wr(`REG_ROLE, 32'h0000_0002);
        wr(`REG_ON_VALUE, P2);
        wr(`REG_OFF_VALUE, P1);
        pv(P3, 1'b0);
        wr(`REG_LIMIT_SRC, 32'h0000_0001);
        st(1'b1);
        pv(P15, 1'b1);
        pv(P05, 1'b0);
        pv(P15, 1'b0);
        pv(P3, 1'b1);
        wr(`REG_ON_VALUE, M1);
        wr(`REG_OFF_VALUE, M2);
        pv(M15, 1'b1);
        pv(M3, 1'b0);
        pv(M15, 1'b0);
        pv(M05, 1'b1);
        wr(`REG_ON_VALUE, P1);
        wr(`REG_OFF_VALUE, P2);
        pv(P3, 1'b0);
        pv(P15, 1'b0);
        pv(P05, 1'b1);
        pv(P15, 1'b1);
        pv(P3, 1'b0);
        wr(`REG_INVERT, 32'h0000_0001);
        st(1'b1);
        pv(P05, 1'b0);
        wr(`REG_INVERT, 32'h0000_0000);
        st(1'b1);
        wr(`REG_ERR_MODE, 32'h0000_0001);
        device_error <= 1'b1;
        st(1'b0);
        wr(`REG_ERR_MODE, 32'h0000_0002);
        pv(P3, 1'b1);
        device_error <= 1'b0;
        st(1'b0);
        wr(`REG_ERR_MODE, 32'h0000_0000);
        device_error <= 1'b1;
        pv(P05, 1'b0);
        device_error <= 1'b0;
        st(1'b1);
        wr(`REG_ON_VALUE, P2);
        wr(`REG_OFF_VALUE, P1);
        pv(32'h0000_0000, 1'b0);
        wr(`REG_ON_DELAY, 32'h0000_0008);
        wr(`REG_OFF_DELAY, 32'h0000_0005);
        pv(P3, 1'b0);
        tick(10);
        pv(P15, 1'b0);
        pv(P3, 1'b0);
        tick(10);
        st(1'b0);
        tick(30);
        st(1'b1);
        pv(P05, 1'b1);
        tick(30);
        st(1'b0);
        tick(2);
        conclude();
    end
endmodule
